// ==== src/dtd_pkg.sv ====
// constants, register map and types of the dual eight-bit timer/divider
// assumes: pclk at 40 MHz, APB slave with 32-bit data, one word per register
package dtd_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CMP_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CMP_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_DUTY_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DUTY_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;

  // control and config register field positions
  localparam int unsigned CTRL_RUN_BIT = 3;
  localparam int unsigned CTRL_FF_BIT = 7;
  localparam int unsigned CFG_PRESRC_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;

  // mode field encodings
  localparam logic [2:0] MODE_TIMER8 = 3'h0;
  localparam logic [2:0] MODE_DIVIDER = 3'h1;
  localparam logic [2:0] MODE_PWM8 = 3'h2;
  localparam logic [2:0] MODE_CASC_LO = 3'h3;
  localparam logic [2:0] MODE_TIMER16 = 3'h4;
  localparam logic [2:0] MODE_WARMUP = 3'h5;
  localparam logic [2:0] MODE_PWM16 = 3'h6;
  localparam logic [2:0] MODE_PPG16 = 3'h7;

  // clock select encodings and prescaler taps
  localparam logic [2:0] CKS_SLOWEST = 3'h0;
  localparam logic [2:0] CKS_DIV7 = 3'h1;
  localparam logic [2:0] CKS_DIV5 = 3'h2;
  localparam logic [2:0] CKS_DIV3 = 3'h3;
  localparam logic [2:0] CKS_SLOW = 3'h4;
  localparam logic [2:0] CKS_DIV1 = 3'h5;
  localparam logic [2:0] CKS_FAST = 3'h6;
  localparam logic [2:0] CKS_PIN = 3'h7;
  localparam int unsigned PRE_W = 11;
  localparam int unsigned SLOW_DIV_W = 3;

  typedef struct packed {
    logic ff_init;
    logic [2:0] clk_sel;
    logic run;
    logic [2:0] mode;
  } dtd_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dtd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dtd_apb_rsp_t;

endpackage : dtd_pkg

// ==== src/dtd_pin_sync.sv ====
// two-flop synchroniser with edge pulses for one pin
// assumes: pin is asynchronous to pclk, pulses last one pclk
module dtd_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic fall,
  output logic rise
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall = prev_reg & ~sync_reg;
  assign rise = ~prev_reg & sync_reg;

endmodule // dtd_pin_sync

// ==== src/dtd_timer.sv ====
// two 8-bit timer/counters with compare, toggle flip-flop and match pulse
// assumes: APB master on pclk; event and slow-clock pins asynchronous
//
// Function
// R1 - timer mode: count ticks, match pulses, clears
// R2 - event mode: count falling pin edges likewise
// R3 - event pin levels held two machine cycles
// R4 - software keeps compare 1..255, duty 2..254
// R5 - cascaded timer compare kept 1..65535
// R6 - warm-up compare kept 256..65535
// R7 - cascaded modulation value kept 2..65534
// R8 - pulse generator: duty plus one below compare
// R9 - slow modes use slowest divided clock only
// R10 - cascade takes clock from lower select field
// R11 - software keeps init bit zero when counting
// R12 - compare value used at once, unbuffered
// R13 - divider match toggles flip-flop, clears, pulses
// R14 - divider pin is inverse of flip-flop
// R15 - flip-flop loads init bit, resets zero
// R16 - software sets port latch before divider
// R17 - stopping holds divider pin level
// R18 - stop first, change init bit later
// R19 - run at bit 3, init at bit 7
// R20 - two counters cascade into 16 bits
// R21 - 3-bit mode field encodings
// R22 - run clear stops and clears counter
// R23 - match pulse one clock, checked each tick
module dtd_timer (
  input wire logic pclk,
  input wire logic presetn,
  input dtd_pkg::dtd_apb_req_t apb_req,
  output dtd_pkg::dtd_apb_rsp_t apb_rsp,
  input wire logic [1:0] event_input_pin,
  input wire logic slow_clk_pin,
  output logic [1:0] match_irq,
  output logic [1:0] divider_out_pin
);
  import dtd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  typedef enum {
    ST_IDLE,
    ST_ACCESS
  } dtd_bus_state_t;

  dtd_bus_state_t bus_state_reg;
  dtd_ctrl_t ctrl_reg [2];
  logic [7:0] compare_value_reg [2];
  logic [7:0] duty_value_reg [2];
  logic prescaler_source_select;
  logic [7:0] cnt_reg [2];
  logic [7:0] cnt_next [2];
  logic ff_reg [2];
  logic ff_next [2];
  logic [PRE_W-1:0] pre_reg;
  logic [SLOW_DIV_W-1:0] slow_div_reg;
  logic [1:0] match_irq_reg;
  logic [1:0] div_pin_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [1:0] ev_fall;
  logic slow_rise;
  logic slowest_tick;
  logic cascade;
  logic run_eff [2];
  logic tick [2];
  logic match [2];
  logic match16;
  logic wr_en;
  logic [1:0] ctrl_wr;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  dtd_pin_sync u_ev0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(event_input_pin[0]),
    .level(),
    .fall(ev_fall[0]),
    .rise()
  );

  dtd_pin_sync u_ev1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(event_input_pin[1]),
    .level(),
    .fall(ev_fall[1]),
    .rise()
  );

  dtd_pin_sync u_slow (
    .pclk(pclk),
    .presetn(presetn),
    .pin(slow_clk_pin),
    .level(),
    .fall(),
    .rise(slow_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and source selection

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_div_reg <= '0;
    end else if (slow_rise) begin
      slow_div_reg <= slow_div_reg + 1'b1;
    end
  end

  // slowest tap: fast/2^11 or slow/2^3
  assign slowest_tick = prescaler_source_select ? (slow_rise && (&slow_div_reg)) : (&pre_reg);

  function automatic logic src_tick(input logic [2:0] sel, input logic [PRE_W-1:0] pre,
                                    input logic slowest, input logic slow, input logic ev);
    case (sel)
      CKS_SLOWEST: src_tick = slowest;
      CKS_DIV7: src_tick = &pre[6:0];
      CKS_DIV5: src_tick = &pre[4:0];
      CKS_DIV3: src_tick = &pre[2:0];
      CKS_SLOW: src_tick = slow;
      CKS_DIV1: src_tick = pre[0];
      CKS_FAST: src_tick = 1'b1;
      default: src_tick = ev;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // count, compare and cascade

  assign cascade = ctrl_reg[1].mode[2]; // R20 R21

  always_comb begin
    run_eff[1] = ctrl_reg[1].run;
    run_eff[0] = cascade ? ctrl_reg[1].run : ctrl_reg[0].run;
    // lower select drives both halves when cascaded
    tick[0] = src_tick(ctrl_reg[0].clk_sel, pre_reg, slowest_tick, slow_rise, ev_fall[0]); // R1 R2 R10
    if (cascade) begin
      tick[1] = tick[0] && (cnt_reg[0] == 8'hFF); // R10 R20
    end else begin
      tick[1] = src_tick(ctrl_reg[1].clk_sel, pre_reg, slowest_tick, slow_rise, ev_fall[1]);
    end
    // compare against the live register value
    match16 = run_eff[1] && tick[0] &&
              (({cnt_reg[1], cnt_reg[0]} + 16'h0001) == {compare_value_reg[1], compare_value_reg[0]}); // R12 R20
    for (int j = 0; j < 2; j++) begin
      match[j] = run_eff[j] && tick[j] && ((cnt_reg[j] + 8'h01) == compare_value_reg[j]); // R12 R23
    end
    if (cascade) begin
      match[0] = 1'b0;
      match[1] = match16;
    end
  end

  always_comb begin
    for (int j = 0; j < 2; j++) begin
      if (!run_eff[j]) begin
        cnt_next[j] = 8'h00; // R22
      end else if (cascade ? match16 : match[j]) begin
        cnt_next[j] = 8'h00; // R1 R2
      end else if (tick[j]) begin
        cnt_next[j] = cnt_reg[j] + 8'h01; // R1 R2
      end else begin
        cnt_next[j] = cnt_reg[j];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg[0] <= 8'h00;
      cnt_reg[1] <= 8'h00;
    end else begin
      cnt_reg[0] <= cnt_next[0];
      cnt_reg[1] <= cnt_next[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_reg <= 2'b00;
    end else begin
      match_irq_reg <= {match[1], match[0]}; // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle flip-flop and divider pin

  always_comb begin
    for (int j = 0; j < 2; j++) begin
      if (ctrl_wr[j] && !ctrl_reg[j].run) begin
        ff_next[j] = apb_req.pwdata[CTRL_FF_BIT]; // R15 R19
      end else if (match[j] && !cascade && ctrl_reg[j].mode == MODE_DIVIDER) begin
        ff_next[j] = ~ff_reg[j]; // R13
      end else begin
        ff_next[j] = ff_reg[j]; // R17
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_reg[0] <= 1'b0; // R15
      ff_reg[1] <= 1'b0;
      div_pin_reg <= 2'b11;
    end else begin
      ff_reg[0] <= ff_next[0];
      ff_reg[1] <= ff_next[1];
      div_pin_reg <= {~ff_next[1], ~ff_next[0]}; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && (bus_state_reg == ST_ACCESS);
  assign ctrl_wr[0] = wr_en && (apb_req.paddr == OFF_CTRL_LO);
  assign ctrl_wr[1] = wr_en && (apb_req.paddr == OFF_CTRL_HI);

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a, input logic wr);
    case (a)
      OFF_CTRL_LO, OFF_CTRL_HI, OFF_CMP_LO, OFF_CMP_HI, OFF_DUTY_LO, OFF_DUTY_HI, OFF_CFG: addr_ok = 1'b1;
      OFF_COUNT, OFF_STATUS: addr_ok = !wr;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_reg <= ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      case (bus_state_reg)
        ST_IDLE: begin
          if (apb_req.psel && !apb_req.penable) begin
            bus_state_reg <= ST_ACCESS;
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_ok(apb_req.paddr, apb_req.pwrite);
            prdata_reg <= 32'h0000_0000;
            if (!apb_req.pwrite) begin
              case (apb_req.paddr)
                OFF_CTRL_LO: prdata_reg <= {24'h00_0000, ctrl_reg[0]};
                OFF_CTRL_HI: prdata_reg <= {24'h00_0000, ctrl_reg[1]};
                OFF_CMP_LO: prdata_reg <= {24'h00_0000, compare_value_reg[0]};
                OFF_CMP_HI: prdata_reg <= {24'h00_0000, compare_value_reg[1]};
                OFF_DUTY_LO: prdata_reg <= {24'h00_0000, duty_value_reg[0]};
                OFF_DUTY_HI: prdata_reg <= {24'h00_0000, duty_value_reg[1]};
                OFF_CFG: prdata_reg <= {31'h0000_0000, prescaler_source_select};
                OFF_COUNT: prdata_reg <= {16'h0000, cnt_reg[1], cnt_reg[0]};
                OFF_STATUS: prdata_reg <= {28'h000_0000, div_pin_reg, ff_reg[1], ff_reg[0]};
                default: prdata_reg <= 32'h0000_0000;
              endcase
            end
          end
        end
        ST_ACCESS: begin
          bus_state_reg <= ST_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
        default: begin
          bus_state_reg <= ST_IDLE;
          pready_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg[0] <= CTRL_RST;
      ctrl_reg[1] <= CTRL_RST;
      compare_value_reg[0] <= CMP_RST;
      compare_value_reg[1] <= CMP_RST;
      duty_value_reg[0] <= DUTY_RST;
      duty_value_reg[1] <= DUTY_RST;
      prescaler_source_select <= 1'b0;
    end else if (wr_en) begin
      case (apb_req.paddr)
        OFF_CTRL_LO: ctrl_reg[0] <= apb_req.pwdata[7:0]; // R19 R21 R22
        OFF_CTRL_HI: ctrl_reg[1] <= apb_req.pwdata[7:0];
        OFF_CMP_LO: compare_value_reg[0] <= apb_req.pwdata[7:0]; // R12
        OFF_CMP_HI: compare_value_reg[1] <= apb_req.pwdata[7:0];
        OFF_DUTY_LO: duty_value_reg[0] <= apb_req.pwdata[7:0];
        OFF_DUTY_HI: duty_value_reg[1] <= apb_req.pwdata[7:0];
        OFF_CFG: prescaler_source_select <= apb_req.pwdata[CFG_PRESRC_BIT];
        default: ;
      endcase
    end
  end

  assign apb_rsp.pready = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;
  assign apb_rsp.prdata = prdata_reg;
  assign match_irq = match_irq_reg;
  assign divider_out_pin = div_pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_apb_setup;
    apb_req.psel && !apb_req.penable && bus_state_reg == ST_IDLE;
  endsequence

  sequence s_lo_div_match;
    match[0] && ctrl_reg[0].mode == MODE_DIVIDER && !cascade;
  endsequence

  a_apb_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb ready not one cycle after setup");

  a_stop_clears_cnt: assert property (@(posedge pclk) disable iff (!presetn) // R22
    !run_eff[0] |=> cnt_reg[0] == 8'h00)
    else $error("stopped counter not cleared");

  a_count_steps_up: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (run_eff[0] && tick[0] && !match[0] && !match16) |=> cnt_reg[0] == $past(cnt_reg[0]) + 8'h01)
    else $error("counter did not step on tick");

  a_match_irq_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R23
    (!cascade && run_eff[0] && tick[0] && (cnt_reg[0] + 8'h01) == compare_value_reg[0])
      |=> match_irq[0] && cnt_reg[0] == 8'h00)
    else $error("match did not pulse and clear");

  a_cmp_used_now: assert property (@(posedge pclk) disable iff (!presetn) // R12
    match_irq[0] |-> $past(cnt_reg[0]) + 8'h01 == $past(compare_value_reg[0]))
    else $error("match against stale compare value");

  a_div_toggles_ff: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (s_lo_div_match and !ctrl_wr[0]) |=> ff_reg[0] != $past(ff_reg[0]) && match_irq[0])
    else $error("divider match did not toggle");

  a_pin_inverts_ff: assert property (@(posedge pclk) disable iff (!presetn) // R14
    divider_out_pin[1] == ~ff_reg[1] && divider_out_pin[0] == ~ff_reg[0])
    else $error("divider pin not inverse of flip-flop");

  a_stop_holds_pin: assert property (@(posedge pclk) disable iff (!presetn) // R17
    (!ctrl_reg[0].run && !ctrl_wr[0] && !cascade) |=> $stable(divider_out_pin[0]))
    else $error("divider pin moved after stop");

  a_init_loads_ff: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (ctrl_wr[0] && !ctrl_reg[0].run) |=> ff_reg[0] == $past(apb_req.pwdata[7]))
    else $error("flip-flop not loaded from init bit");

  a_cascade_carry: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (cascade && run_eff[1] && tick[0] && cnt_reg[0] == 8'hFF && !match16)
      |=> cnt_reg[1] == $past(cnt_reg[1]) + 8'h01 && cnt_reg[0] == 8'h00)
    else $error("cascade carry missed");

endmodule // dtd_timer

// ==== verification/tb_top.sv ====
// self-checking bench for the dual eight-bit timer/divider
// assumes: dtd_pkg compiled first, design asserts live in the design files
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dtd_pkg::*;

  logic pclk;
  logic presetn;
  dtd_apb_req_t apb_req;
  dtd_apb_rsp_t apb_rsp;
  logic [1:0] event_input_pin;
  logic slow_clk_pin = 1'b0;
  logic slow_on = 1'b0;
  logic [1:0] match_irq;
  logic [1:0] divider_out_pin;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int hits0 = 0;

  dtd_timer dut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .event_input_pin(event_input_pin),
    .slow_clk_pin(slow_clk_pin),
    .match_irq(match_irq),
    .divider_out_pin(divider_out_pin)
  );

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // free-running slow clock, one rise every second pclk while enabled
  always @(posedge pclk) begin
    if (slow_on) begin
      slow_clk_pin <= ~slow_clk_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, tests need a few thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (match_irq[0] === 1'b1) hits0 <= hits0 + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h00_0000, d}, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  // edges until a match pulse on one counter, bounded
  task automatic wait_irq(input int idx, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (match_irq[idx] !== 1'b1 && n < 2000);
  endtask

  // low and high each held four clocks
  task automatic ev_pulse();
    @(posedge pclk);
    event_input_pin[0] <= 1'b0;
    repeat (4) @(posedge pclk);
    event_input_pin[0] <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({30'h0, divider_out_pin}, 32'h0000_0003);
    chk({30'h0, match_irq}, 32'h0000_0000);
    rd_chk(OFF_CTRL_LO, 32'h0000_0000, 1'b0);
    rd_chk(OFF_CMP_LO, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_timer();
    int n;
    wr(OFF_CMP_LO, 8'h03);
    wr(OFF_CTRL_LO, 8'h68);
    wait_irq(0, n);
    wait_irq(0, n);
    chk(n, 3);
    wr(OFF_CMP_LO, 8'h05);
    wait_irq(0, n);
    wait_irq(0, n);
    chk(n, 5);
    wr(OFF_CTRL_LO, 8'h60);
    rd_chk(OFF_COUNT, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_divider();
    int n;
    logic p;
    wr(OFF_CMP_LO, 8'h02);
    wr(OFF_CTRL_LO, 8'h61);
    rd_chk(OFF_CTRL_LO, 32'h0000_0061, 1'b0);
    chk({31'h0, divider_out_pin[0]}, 32'h0000_0001);
    wr(OFF_CTRL_LO, 8'h69);
    wait_irq(0, n);
    p = divider_out_pin[0];
    wait_irq(0, n);
    chk(n, 2);
    chk({31'h0, divider_out_pin[0]}, {31'h0, ~p});
    wr(OFF_CTRL_LO, 8'hE9);
    wr(OFF_CTRL_LO, 8'hE1);
    @(posedge pclk);
    p = divider_out_pin[0];
    n = hits0;
    repeat (10) @(posedge pclk);
    chk({31'h0, divider_out_pin[0]}, {31'h0, p});
    chk(hits0 - n, 0);
    wr(OFF_CTRL_LO, 8'hE1);
    repeat (2) @(posedge pclk);
    chk({31'h0, divider_out_pin[0]}, 32'h0000_0000);
    wr(OFF_CTRL_LO, 8'h61);
    repeat (2) @(posedge pclk);
    chk({31'h0, divider_out_pin[0]}, 32'h0000_0001);
    rd_chk(OFF_STATUS, 32'h0000_000C, 1'b0);
  endtask

  task automatic t_event();
    int h;
    wr(OFF_CMP_LO, 8'h03);
    wr(OFF_CTRL_LO, 8'h78);
    h = hits0;
    repeat (2) ev_pulse();
    chk(hits0 - h, 0);
    ev_pulse();
    repeat (4) @(posedge pclk);
    chk(hits0 - h, 1);
    repeat (3) ev_pulse();
    repeat (4) @(posedge pclk);
    chk(hits0 - h, 2);
    wr(OFF_CTRL_LO, 8'h70);
  endtask

  // slowest tap from the slow pin, then warm-up on slow ticks
  task automatic t_slow();
    int n;
    slow_on <= 1'b1;
    wr(OFF_CFG, 8'h01);
    rd_chk(OFF_CFG, 32'h0000_0001, 1'b0);
    wr(OFF_CMP_LO, 8'h02);
    wr(OFF_CTRL_LO, 8'h08);
    wait_irq(0, n);
    wait_irq(0, n);
    chk(n, 32);
    wr(OFF_CTRL_LO, 8'h00);
    wr(OFF_CFG, 8'h00);
    wr(OFF_CMP_LO, 8'h00);
    wr(OFF_CMP_HI, 8'h01);
    wr(OFF_CTRL_LO, 8'h43);
    wr(OFF_CTRL_HI, 8'h0D);
    wait_irq(1, n);
    wait_irq(1, n);
    chk(n, 512);
    wr(OFF_CTRL_HI, 8'h05);
    slow_on <= 1'b0;
  endtask

  task automatic t_cascade();
    int n;
    int h;
    wr(OFF_CMP_LO, 8'h02);
    wr(OFF_CMP_HI, 8'h01);
    wr(OFF_DUTY_LO, 8'hFE);
    wr(OFF_DUTY_HI, 8'h00);
    rd_chk(OFF_DUTY_LO, 32'h0000_00FE, 1'b0);
    rd_chk(OFF_DUTY_HI, 32'h0000_0000, 1'b0);
    wr(OFF_CTRL_LO, 8'h63);
    wr(OFF_CTRL_HI, 8'h0C);
    h = hits0;
    wait_irq(1, n);
    wait_irq(1, n);
    chk(n, 258);
    chk(hits0 - h, 0);
    wr(OFF_CTRL_HI, 8'h04);
  endtask

  task automatic t_refused();
    logic [31:0] r;
    logic e;
    rd_chk(8'h24, 32'h0000_0000, 1'b1);
    apb(1'b1, OFF_COUNT, 32'h0000_00FF, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    rd_chk(OFF_COUNT, 32'h0000_0000, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    event_input_pin = 2'b11;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_timer();
    t_divider();
    t_event();
    t_slow();
    t_cascade();
    t_refused();
    final_report();
  end
endmodule // tb_top
